// ==== core/video_luma_denoise_filter.sv ====
// luma denoise: tile statistics, history update, per-pixel filter, output buffer
`include "dn_cfg.svh"
`default_nettype none
module video_luma_denoise_filter import dn_pkg::*; (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       deinterlace_enable,
  input  wire logic       noise_reduce_enable,
  input  wire layout_t    layout,
  input  wire logic [11:0] motion_sum_threshold,
  input  wire logic [4:0] motion_count_threshold,
  input  wire logic [11:0] signed_sum_threshold,
  input  wire logic [12:0] complexity_threshold,
  input  wire logic [5:0] pixel_motion_threshold,
  input  wire logic [5:0] pixel_low_threshold,
  input  wire logic [7:0] neighbour_match_threshold,
  input  wire logic [7:0] history_max,
  input  wire logic [7:0] history_delta,
  input  wire logic       tile_valid,
  output logic            tile_ready,
  input  wire tile_in_t   tile_in,
  input  wire logic       pix_valid,
  output logic            pix_ready,
  input  wire pix_in_t    pix_in,
  output logic            out_valid,
  input  wire logic       out_ready,
  output pix_out_t        out_data,
  output logic            hist_wr_valid,
  output logic [7:0]      hist_wr_data,
  output logic            layout_unsupported,
  output logic            chroma_vertical_double
);
  localparam logic [11:0] NB_LUT [9]  = '{`NB_RECIP_LUT};
  localparam logic [10:0] BL_LUT [16] = '{`BLEND_RECIP_LUT};

  function automatic logic [7:0] absd(input logic [7:0] a, input logic [7:0] b);
    absd = (a >= b) ? (a - b) : (b - a);
  endfunction : absd

  function automatic logic [7:0] avg(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    avg = s[8:1];
  endfunction : avg

  state_t s;
  state_t next_s;

  logic        tile_fire, pix_fire, pop, push, mot_c, ovr_c;
  logic [11:0] stad_c, cpx_h, cpx_v;
  logic [12:0] cpx_c;
  logic [4:0]  mcnt_c;
  logic signed [12:0] ssum_c;
  logic [11:0] tasd_c;
  logic [7:0]  newh_c;
  logic [7:0]  tdiff, tt_c, sp_c, bmax, bmin, out_c;
  logic [3:0]  good_c;
  logic [11:0] gsum;
  logic [23:0] sp_prod;
  logic [16:0] tt_acc;
  logic [5:0]  t6;
  logic [4:0]  span;
  logic [11:0] ws;
  logic [12:0] wt;
  logic [12:0] bacc;
  logic [23:0] bprod;
  logic [7:0]  blk_size;
  pix_out_t    item;

  assign tile_fire = tile_valid && s.tile_rdy;
  assign pix_fire  = pix_valid && s.pix_rdy;
  assign pop       = s.out_vld && out_ready;
  assign push      = pix_fire;
  // block size sent to the shader cores per field
  assign blk_size  = deinterlace_enable ? `BLK_PIX_DI : `BLK_PIX_DN;

  // tile statistics from the interleaved 4x4 of both fields
  always_comb begin
    logic [7:0] d;
    d      = '0;
    stad_c = '0;
    mcnt_c = '0;
    ssum_c = '0;
    cpx_h  = '0;
    cpx_v  = '0;
    for (int i = 0; i < 16; i++) begin
      d      = absd(tile_in.cur[i], tile_in.prev[i]);
      stad_c = stad_c + 12'(d);
      if (d >= 8'(pixel_motion_threshold)) mcnt_c = mcnt_c + 5'h01;
      ssum_c = ssum_c + 13'(signed'({1'b0, tile_in.cur[i]}))
                      - 13'(signed'({1'b0, tile_in.prev[i]}));
      if (i % 4 != 3) cpx_h = cpx_h + 12'(absd(tile_in.cur[i], tile_in.cur[i + 1]));
      if (i < 12)     cpx_v = cpx_v + 12'(absd(tile_in.cur[i], tile_in.cur[i + 4]));
    end
    tasd_c = ssum_c[12] ? 12'(-ssum_c) : ssum_c[11:0];
    cpx_c  = 13'(cpx_h) + 13'(cpx_v);
  end

  // history update; override applies after the static update
  always_comb begin
    mot_c = (stad_c >= motion_sum_threshold) || (mcnt_c > motion_count_threshold);
    ovr_c = (12'(tasd_c) > signed_sum_threshold) && (cpx_c < complexity_threshold);
    if (mot_c) begin
      newh_c = (tile_in.history >= `HIST_MID) ? (tile_in.history >> 1) : 8'h00;
    end else if (tile_in.history < `HIST_MID) begin
      newh_c = `HIST_MID;
    end else if (tile_in.history < history_max) begin
      newh_c = (9'(tile_in.history) + 9'(history_delta) > 9'h0FF) ? 8'hFF
             : tile_in.history + history_delta;
    end else begin
      newh_c = tile_in.history;
    end
    if (!mot_c && ovr_c) newh_c = `HIST_MID;
  end

  // per-pixel temporal, spatial and blend path, unsigned 8-bit in and out
  always_comb begin
    logic [7:0] c;
    c     = pix_in.nbr[`CENTRE_TAP];
    tdiff = absd(c, pix_in.prev);
    t6    = (tdiff > `TDIFF_MAX6) ? 6'h3F : tdiff[5:0];
    tt_acc = 17'(s.hist) * 17'(c) + 17'(`HIST_FULL - 9'(s.hist)) * 17'(pix_in.prev)
           + `TEMP_ROUND;
    tt_c  = tt_acc[`TEMP_SHIFT +: 8];
    bmax  = c;
    bmin  = c;
    good_c = '0;
    gsum  = '0;
    for (int k = 0; k < 9; k++) begin
      if (pix_in.nbr[k] > bmax) bmax = pix_in.nbr[k];
      if (pix_in.nbr[k] < bmin) bmin = pix_in.nbr[k];
      if (k == `CENTRE_TAP || absd(pix_in.nbr[k], c) < neighbour_match_threshold) begin
        good_c = good_c + 4'h1;
        gsum   = gsum + 12'(pix_in.nbr[k]);
      end
    end
    sp_prod = 24'(gsum + 12'(good_c >> 1)) * 24'(NB_LUT[good_c - 4'h1]);
    sp_c    = sp_prod[`SPAT_SHIFT +: 8];
    if (tt_c >= bmax) tt_c = avg(tt_c, bmax);
    if (tt_c < bmin)  tt_c = avg(tt_c, bmin);
    span  = 5'(pixel_motion_threshold - pixel_low_threshold);
    ws    = 12'(sp_c) * 12'(t6 - pixel_low_threshold);
    wt    = 13'(tt_c) * 13'(pixel_motion_threshold - t6);
    bacc  = 13'(ws) + wt + 13'(span >> 1);
    bprod = 24'(bacc) * 24'(BL_LUT[4'(span - 5'h01)]);
    if (!noise_reduce_enable) begin
      out_c = c;
    end else if (6'(tdiff) >= pixel_motion_threshold || tdiff > `TDIFF_MAX6 || s.motion) begin
      out_c = sp_c;
    end else if (t6 < pixel_low_threshold) begin
      out_c = tt_c;
    end else begin
      out_c = bprod[`BLEND_SHIFT +: 8];
    end
  end

  // next state: tile load, pixel consume, two-entry output buffer
  always_comb begin
    next_s = s;
    next_s.hist_wr = 1'b0;
    item.luma = out_c;
    item.last = (s.blk_cnt == blk_size - 8'h01);
    if (tile_fire) begin
      next_s.tile_loaded = 1'b1;
      next_s.motion      = mot_c;
      next_s.hist        = newh_c;
      next_s.hist_wr     = 1'b1;
      next_s.pix_left    = `TILE_PIXELS;
    end
    if (pix_fire) begin
      next_s.pix_left = s.pix_left - 5'h01;
      if (s.pix_left == 5'h01) next_s.tile_loaded = 1'b0;
      next_s.blk_cnt  = item.last ? 8'h00 : s.blk_cnt + 8'h01;
    end
    if (pop) begin
      next_s.fifo[0]  = s.fifo[1];
      next_s.fifo_cnt = s.fifo_cnt - 2'h1;
    end
    if (push) begin
      next_s.fifo[next_s.fifo_cnt[0]] = item;
      next_s.fifo_cnt = next_s.fifo_cnt + 2'h1;
    end
    next_s.out_vld  = (next_s.fifo_cnt != 2'h0);
    next_s.pix_rdy  = next_s.tile_loaded && (next_s.fifo_cnt != 2'h2);
    next_s.tile_rdy = !next_s.tile_loaded;
    next_s.fmt_bad  = (layout == FMT_NV11) || (layout == FMT_P208) || (layout > FMT_P208);
    next_s.chroma_dbl = (layout == FMT_NV12) || (layout == FMT_YV12) || (layout == FMT_I420)
                     || (layout == FMT_IMC3) || (layout == FMT_IMC4);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign tile_ready             = s.tile_rdy;
  assign pix_ready              = s.pix_rdy;
  assign out_valid              = s.out_vld;
  assign out_data               = s.fifo[0];
  assign hist_wr_valid          = s.hist_wr;
  assign hist_wr_data           = s.hist;
  assign layout_unsupported     = s.fmt_bad;
  assign chroma_vertical_double = s.chroma_dbl;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_MOTION_HALVE: assert property (ce && tile_fire && mot_c |=> s.motion &&
    (s.hist == (($past(tile_in.history) >= `HIST_MID) ? ($past(tile_in.history) >> 1) : 8'h00)))
    else $error("motion tile history wrong");
  AST_STATIC_FLOOR: assert property (ce && tile_fire && !mot_c && !ovr_c &&
    tile_in.history < `HIST_MID |=> !s.motion && s.hist == `HIST_MID)
    else $error("static tile not raised to mid");
  AST_OVERRIDE: assert property (ce && tile_fire && !mot_c && ovr_c |=> s.hist == `HIST_MID)
    else $error("override not applied");
  AST_HIST_WRITE: assert property (ce && tile_fire |=> hist_wr_valid && !tile_ready
    && s.pix_left == `TILE_PIXELS
    ##1 !hist_wr_valid || $past(tile_fire))
    else $error("history write missing");
  AST_PIX_AFTER_TILE: assert property (pix_ready |-> s.tile_loaded && s.pix_left != 5'h00)
    else $error("pixel accepted without tile history");
  AST_GOOD_RANGE: assert property (pix_valid |-> good_c >= 4'h1 && good_c <= 4'h9)
    else $error("good neighbour count out of range");
  AST_MOTION_COUNT: assert property (tile_valid |-> mcnt_c <= `TILE_PIXELS && stad_c <= 12'hFF0)
    else $error("tile statistic out of range");
  AST_BLOCK_LAST: assert property (ce && push && item.last |=> s.blk_cnt == 8'h00)
    else $error("block end misplaced");
  AST_FIFO_LEVEL: assert property (s.fifo_cnt <= 2'h2 && out_valid == (s.fifo_cnt != 2'h0))
    else $error("output buffer level broken");
  AST_SPATIAL_ON_MOTION: assert property (noise_reduce_enable && s.motion |-> out_c == sp_c)
    else $error("motion tile not spatial");

  COV_MOTION_TILE: cover property (ce && tile_fire && mot_c);
  COV_BLEND: cover property (pix_fire && noise_reduce_enable && !s.motion
    && t6 >= pixel_low_threshold && 6'(tdiff) < pixel_motion_threshold);
  COV_FIFO_FULL: cover property (s.fifo_cnt == 2'h2 && !out_ready);
  COV_BLOCK_END: cover property (pop && out_data.last);
endmodule : video_luma_denoise_filter
`default_nettype wire

// ==== core/dn_cfg.svh ====
// constants of the luma denoise filter
`ifndef DN_CFG_SVH
`define DN_CFG_SVH
`define HIST_MID        8'h80
`define HIST_FULL       9'h100
`define TEMP_ROUND      17'h00080
`define TEMP_SHIFT      8
`define SPAT_SHIFT      11
`define BLEND_SHIFT     10
`define TILE_PIXELS     5'h10
`define BLK_PIX_DI      8'h40
`define BLK_PIX_DN      8'h80
`define CENTRE_TAP      4
`define TDIFF_MAX6      8'h3F
`define NB_RECIP_LUT    12'h800, 12'h400, 12'h2AA, 12'h200, 12'h199, \
                        12'h155, 12'h124, 12'h100, 12'h0E3
`define BLEND_RECIP_LUT 11'h400, 11'h200, 11'h155, 11'h100, 11'h0CD, 11'h0AB, \
                        11'h092, 11'h080, 11'h072, 11'h066, 11'h05D, 11'h055, \
                        11'h04F, 11'h049, 11'h044, 11'h040
`endif

// ==== core/dn_pkg.sv ====
// types of the luma denoise filter
`default_nettype none
package dn_pkg;
  typedef enum logic [3:0] {
    FMT_NV12, FMT_UYVY, FMT_YUY2, FMT_YV12, FMT_I420, FMT_IMC3, FMT_IMC4, FMT_NV11, FMT_P208
  } layout_t;
  typedef struct packed {
    logic [15:0][7:0] cur;
    logic [15:0][7:0] prev;
    logic [7:0]       history;
  } tile_in_t;
  typedef struct packed {
    logic [8:0][7:0] nbr;
    logic [7:0]      prev;
  } pix_in_t;
  typedef struct packed {
    logic [7:0] luma;
    logic       last;
  } pix_out_t;
  typedef struct packed {
    logic            tile_loaded;
    logic            motion;
    logic [7:0]      hist;
    logic [4:0]      pix_left;
    logic [7:0]      blk_cnt;
    logic            hist_wr;
    pix_out_t [1:0]  fifo;
    logic [1:0]      fifo_cnt;
    logic            out_vld;
    logic            pix_rdy;
    logic            tile_rdy;
    logic            fmt_bad;
    logic            chroma_dbl;
  } state_t;
endpackage : dn_pkg
`default_nettype wire

// ==== verification/shader_core_sink.sv ====
// far-side sink model: takes filtered words from the filter, optionally stalling
`default_nettype none
module shader_core_sink (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic slow,
  output var  logic out_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt;
  // ready moves only at falling edges; when slow it stalls three cycles out of four
  always @(negedge clk) begin
    cnt <= sys_rst ? 2'h0 : cnt + 2'h1;
    out_ready <= !sys_rst && (!slow || cnt == 2'h0);
  end
endmodule : shader_core_sink
`default_nettype wire

// ==== verification/video_luma_denoise_filter_test.sv ====
// self-checking bench for the luma denoise filter
`default_nettype none
module video_luma_denoise_filter_test import dn_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, sys_rst, tile_valid, tile_ready, pix_valid, pix_ready, di, dn, slow, ce;
  logic        out_valid, out_ready, hist_wr_valid, unsup, dbl;
  logic [7:0]  hist_wr_data, seed, nthr, hmax, hdelta;
  logic [11:0] mst, sst;
  logic [12:0] cxt;
  logic [4:0]  mct;
  logic [5:0]  pmt, low;
  layout_t     layout;
  tile_in_t    ti;
  pix_in_t     pi;
  pix_out_t    od;
  logic [7:0]  hq[$];
  logic [8:0]  oq[$];
  int          err_count, tests_run, pc;
  logic [7:0]  htab[6] = '{8'h00, 8'h7F, 8'h80, 8'hEF, 8'hF0, 8'hFA};
  int          gq[9] = '{2048, 1024, 682, 512, 409, 341, 292, 256, 227};
  int          qq[16] = '{1024, 512, 341, 256, 205, 171, 146, 128, 114, 102, 93, 85, 79, 73, 68, 64};

  video_luma_denoise_filter dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .deinterlace_enable(di), .noise_reduce_enable(dn), .layout(layout),
    .motion_sum_threshold(mst), .motion_count_threshold(mct), .signed_sum_threshold(sst),
    .complexity_threshold(cxt), .pixel_motion_threshold(pmt), .pixel_low_threshold(low),
    .neighbour_match_threshold(nthr), .history_max(hmax), .history_delta(hdelta),
    .tile_valid(tile_valid), .tile_ready(tile_ready), .tile_in(ti), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_in(pi), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(od), .hist_wr_valid(hist_wr_valid), .hist_wr_data(hist_wr_data),
    .layout_unsupported(unsup), .chroma_vertical_double(dbl));
  shader_core_sink sink (.clk(clk), .sys_rst(sys_rst), .slow(slow), .out_ready(out_ready));

  always #12.5 clk = ~clk;

  function automatic int ad(int a, int b);
    return a > b ? a - b : b - a;
  endfunction : ad

  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction : rnd

  // expected {motion, new history} of one tile
  function automatic logic [8:0] tile_ref(tile_in_t t);
    int st = 0;
    int mc = 0;
    int ss = 0;
    int cx = 0;
    int h = t.history;
    int nh;
    for (int i = 0; i < 16; i++) begin
      ss += int'(t.cur[i]) - int'(t.prev[i]);
      st += ad(t.cur[i], t.prev[i]);
      mc += ad(t.cur[i], t.prev[i]) >= pmt;
      if (i % 4 < 3) cx += ad(t.cur[i], t.cur[i + 1]);
      if (i < 12) cx += ad(t.cur[i], t.cur[i + 4]);
    end
    if (st >= mst || mc > mct) return {1'b1, h >= 128 ? 8'(h >> 1) : 8'h00};
    nh = h < 128 ? 128 : h < hmax ? (h + hdelta > 255 ? 255 : h + hdelta) : h;
    if (ad(ss, 0) > sst && cx < cxt) nh = 128;
    return {1'b0, 8'(nh)};
  endfunction : tile_ref

  // expected output luma of one pixel
  function automatic logic [7:0] pix_ref(logic [8:0] tr, pix_in_t p);
    int c = p.nbr[4];
    int d = ad(c, p.prev) > 63 ? 63 : ad(c, p.prev);
    int t = (tr[7:0] * c + (256 - tr[7:0]) * p.prev + 128) >> 8;
    int mx = 0;
    int mn = 255;
    int s = 0;
    int n = 0;
    int sp;
    for (int k = 0; k < 9; k++) begin
      if (p.nbr[k] > mx) mx = p.nbr[k];
      if (p.nbr[k] < mn) mn = p.nbr[k];
      if (ad(p.nbr[k], c) < nthr) begin
        s += p.nbr[k];
        n++;
      end
    end
    if (!dn) return c[7:0];
    if (t >= mx) t = (t + mx) >> 1;
    if (t < mn) t = (t + mn) >> 1;
    sp = ((s + (n >> 1)) * gq[n - 1]) >> 11;
    if (d >= pmt || tr[8]) return sp[7:0];
    if (d < low) return t[7:0];
    return 8'(((sp * (d - low) + t * (pmt - d) + (pmt - low) / 2) * qq[pmt - low - 1]) >> 10);
  endfunction : pix_ref

  task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // kind 0 quiet, 1 moving, 2 flat with steady offset; entered and left at a falling edge
  task automatic send_tile(int kind, logic [7:0] h);
    logic [8:0] tr;
    logic [7:0] base;
    base = rnd() | 8'h10;
    for (int i = 0; i < 16; i++) begin
      ti.cur[i] = kind == 2 ? base : rnd();
      ti.prev[i] = kind == 1 ? rnd() : ti.cur[i] - (kind == 2 ? 8'h05 : 8'(rnd() % 24) - 8'h0C);
    end
    ti.history = h;
    tr = tile_ref(ti);
    while (!tile_ready) @(negedge clk);
    tile_valid = 1'b1;
    hq.push_back(tr[7:0]);
    @(negedge clk);
    tile_valid = 1'b0;
    chk("tile handshake", 9'h001, {7'h00, tile_ready, hist_wr_valid});
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < 9; k++) pi.nbr[k] = ti.cur[i] + 8'(rnd() % 48) - 8'h18;
      pi.nbr[4] = ti.cur[i];
      pi.prev = ti.prev[i];
      while (!pix_ready) begin
        pix_valid = 1'b0;
        @(negedge clk);
      end
      pix_valid = 1'b1;
      pc = (pc + 1) % (di ? 64 : 128);
      oq.push_back({pix_ref(tr, pi), pc == 0});
      @(negedge clk);
    end
    pix_valid = 1'b0;
  endtask : send_tile

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    if (ce && hist_wr_valid) chk("history", {1'b0, hq.pop_front()}, {1'b0, hist_wr_data});
    if (ce && out_valid && out_ready) chk("pixel", oq.pop_front(), od);
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial begin
    {clk, tile_valid, pix_valid, slow, err_count, tests_run, pc} = '0;
    {sys_rst, di, dn, seed, ti, pi} = {3'b111, 8'h43, 264'h0, 80'h0};
    layout = FMT_NV12;
    ce = 1'b1;
    {mst, mct, sst, cxt, nthr, hmax, hdelta} = {12'h0C0, 5'h06, 12'h040, 13'h0200, 24'h10F008};
    pmt = 6'h14;
    low = 6'h04;
    repeat (2) @(negedge clk);
    chk("reset ready", 9'h000, {7'h00, tile_ready, out_valid});
    sys_rst = 1'b0;
    for (int i = 0; i < 10; i++) begin
      layout = i < 9 ? layout_t'(i) : layout_t'(4'hF);
      @(negedge clk);
      chk("layout", {7'h00, i > 6, i inside {0, 3, 4, 5, 6}}, {7'h00, unsup, dbl});
    end
    // freeze: flags must hold while the layout changes under a low enable
    ce = 1'b0;
    layout = FMT_NV12;
    repeat (2) @(negedge clk);
    chk("freeze", 9'h002, {7'h00, unsup, dbl});
    ce = 1'b1;
    for (int t = 0; t < 24; t++) begin
      if (t == 8) begin
        {di, slow, hmax} = {2'b01, 8'hFF};
        {pmt, low} = {6'h08, 6'h07};
      end
      if (t == 16) {di, dn, slow} = 3'b100;
      send_tile(t % 3, t % 4 == 3 ? rnd() : htab[(t + t / 3) % 6]);
    end
    for (int i = 0; i < 300 && oq.size() > 0; i++) @(negedge clk);
    chk("drained", 9'h000, {8'(oq.size() + hq.size()), 1'b0});
    print_verdict();
  end
endmodule : video_luma_denoise_filter_test
`default_nettype wire
